/* File: logic/atl_limit_regs.sv */
// Alert threshold registers, limit comparators and limit flags
// Operation
// - Hold signed shunt over threshold; compare each shunt result for overcurrent.
// - Negative shunt over threshold trips even for a zero shunt result.
// - Shunt thresholds weigh 5 uV or 1.25 uV per count by range select.
// - Hold signed shunt under threshold; compare each shunt result for undercurrent.
// - Bus over threshold is 15 bits unsigned; bit 15 reads zero.
// - Bus under threshold is 15 bits unsigned; bit 15 reads zero.
// - Bus thresholds weigh 3.125 mV per count like the bus result.
// - Temperature limit is signed 12 bits in 15:4, compared to die temperature.
// - Temperature limit bits 3:0 always read zero.
// - Power limit is 16 bits unsigned, 256 power steps per count.
// - Read-only maker identification word.
// - Reset gives non-tripping limits: shunt under 8000h, bus under 0, power FFFFh.
// - Over flags set above threshold, under flags set below threshold.
// - Latched flags hold until diagnostic read; transparent flags follow the fault.
`timescale 1ns/100ps
`default_nettype none
module atl_limit_regs #(
    // Arbitrary value, not a real maker code
    parameter logic [15:0] MAKER_ID = 16'h4142
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [7:0]          regAddr,
    input  wire logic                regWrEn,
    input  wire logic [15:0]         regWrData,
    input  wire logic                regRdEn,
    output logic      [15:0]         regRdData,
    input  wire atl_pkg::atl_meas_t  meas,
    input  wire logic                shuntRangeSelect,
    input  wire logic                alertLatchEnable,
    input  wire logic                diagRead,
    output logic      [15:0]         shuntStepNv,
    output atl_pkg::atl_flags_t      limitFlags,
    output logic                     limitAlert
);
    logic [15:0] shuntOver_r;
    logic [15:0] shuntUnder_r;
    logic [15:0] busOver_r;
    logic [15:0] busUnder_r;
    logic [15:0] tempLimit_r;
    logic [15:0] powerLimit_r;
    logic [15:0] rdData_r;
    logic [15:0] shuntStep_r;
    logic [atl_pkg::NUM_FLAGS-1:0] flags_r;
    logic        alert_r;

    // Address decode
    wire hitShuntOver = regAddr == atl_pkg::ADDR_SHUNT_OVER;
    wire hitShuntUnder = regAddr == atl_pkg::ADDR_SHUNT_UNDER;
    wire hitBusOver = regAddr == atl_pkg::ADDR_BUS_OVER;
    wire hitBusUnder = regAddr == atl_pkg::ADDR_BUS_UNDER;
    wire hitTemp = regAddr == atl_pkg::ADDR_TEMP_LIMIT;
    wire hitPower = regAddr == atl_pkg::ADDR_POWER_LIMIT;
    wire hitMaker = regAddr == atl_pkg::ADDR_MAKER_ID;

    wire [15:0] wrTemp = regWrData & atl_pkg::MASK_TEMP;
    wire [15:0] wrBus = regWrData & atl_pkg::MASK_BUS;

    // Read mux; unmapped addresses return zero
    wire [15:0] rdMux =
        hitShuntOver  ? shuntOver_r  :
        hitShuntUnder ? shuntUnder_r :
        hitBusOver    ? busOver_r    :
        hitBusUnder   ? busUnder_r   :
        hitTemp       ? tempLimit_r  :
        hitPower      ? powerLimit_r :
        hitMaker      ? MAKER_ID     : atl_pkg::REG_ZERO;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shuntOver_r  <= atl_pkg::RST_SHUNT_OVER;
            shuntUnder_r <= atl_pkg::RST_SHUNT_UNDER;
            busOver_r    <= atl_pkg::RST_BUS_OVER;
            busUnder_r   <= atl_pkg::RST_BUS_UNDER;
            tempLimit_r  <= atl_pkg::RST_TEMP_LIMIT;
            powerLimit_r <= atl_pkg::RST_POWER_LIMIT;
        end else if (regWrEn) begin
            if (hitShuntOver) shuntOver_r <= regWrData;
            if (hitShuntUnder) shuntUnder_r <= regWrData;
            if (hitBusOver) busOver_r <= wrBus;
            if (hitBusUnder) busUnder_r <= wrBus;
            if (hitTemp) tempLimit_r <= wrTemp;
            if (hitPower) powerLimit_r <= regWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData_r <= atl_pkg::REG_ZERO;
        end else if (regRdEn) begin
            rdData_r <= rdMux;
        end
    end

    wire [15:0] stepNxt = shuntRangeSelect ? atl_pkg::SHUNT_STEP_NARROW_NV
                                           : atl_pkg::SHUNT_STEP_WIDE_NV;
    always_ff @(posedge core_clk) begin
        if (rst) shuntStep_r <= atl_pkg::SHUNT_STEP_WIDE_NV;
        else shuntStep_r <= stepNxt;
    end

    wire tripShuntOver = $signed(meas.shunt) > $signed(shuntOver_r);
    wire tripShuntUnder = $signed(meas.shunt) < $signed(shuntUnder_r);
    wire tripBusOver = meas.bus > busOver_r;
    wire tripBusUnder = meas.bus < busUnder_r;
    wire tripTemp = $signed(meas.temp) >
                    $signed(tempLimit_r[15:atl_pkg::TEMP_LSB_POS]);
    wire tripPower = meas.power[23:atl_pkg::POWER_CMP_POS] > powerLimit_r;

    // Bit order matches atl_flags_t
    wire [atl_pkg::NUM_FLAGS-1:0] newValid = {meas.tempValid,
        meas.shuntValid, meas.shuntValid, meas.busValid, meas.busValid,
        meas.powerValid};
    wire [atl_pkg::NUM_FLAGS-1:0] trip = {tripTemp, tripShuntOver,
        tripShuntUnder, tripBusOver, tripBusUnder, tripPower};
    wire  [atl_pkg::NUM_FLAGS-1:0] flags_nxt;

    // Flags only set on a fresh result so stale inputs never trip; latched flags also clear on a diagnostic read
    genvar gi;
    generate
        for (gi = 0; gi < atl_pkg::NUM_FLAGS; gi++) begin : g_flag
            assign flags_nxt[gi] =
                (newValid[gi] && trip[gi]) ? 1'b1 :
                (alertLatchEnable ? (flags_r[gi] && !diagRead)
                                  : (newValid[gi] ? 1'b0 : flags_r[gi]));
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_r <= '0;
            alert_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            alert_r <= |flags_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign shuntStepNv = shuntStep_r;
    assign limitFlags = atl_pkg::atl_flags_t'(flags_r);
    assign limitAlert = alert_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence shuntTripS;
        meas.shuntValid && ($signed(meas.shunt) > $signed(shuntOver_r));
    endsequence
    sequence heldNoReadS;
        alertLatchEnable && !diagRead && !meas.shuntValid;
    endsequence

    shunt_over_set_a: assert property (
        shuntTripS |=> limitFlags.shuntOver && limitAlert)
        else $error("shunt over flag not set");
    latch_hold_a: assert property (
        shuntTripS ##1 heldNoReadS [*2] |=> limitFlags.shuntOver)
        else $error("latched flag lost");
    zero_negative_a: assert property (
        meas.shuntValid && meas.shunt == 16'h0000 && shuntOver_r[15]
        |=> limitFlags.shuntOver)
        else $error("zero result missed negative limit");
    shunt_under_set_a: assert property (
        meas.shuntValid && $signed(meas.shunt) < $signed(shuntUnder_r)
        |=> limitFlags.shuntUnder)
        else $error("shunt under flag not set");
    transparent_clear_a: assert property (
        !alertLatchEnable && meas.busValid && !(meas.bus > busOver_r)
        |=> !limitFlags.busOver)
        else $error("transparent flag stuck");
    diag_clear_a: assert property (
        alertLatchEnable && diagRead && !meas.shuntValid
        |=> !limitFlags.shuntOver)
        else $error("diagnostic read did not clear");
    bus_reserved_a: assert property (
        regRdEn && (hitBusOver || hitBusUnder)
        |=> (regRdData & ~atl_pkg::MASK_BUS) == atl_pkg::REG_ZERO)
        else $error("bus reserved bit set");
    temp_reserved_a: assert property (
        regRdEn && hitTemp
        |=> (regRdData & ~atl_pkg::MASK_TEMP) == atl_pkg::REG_ZERO)
        else $error("temperature reserved bits set");
    temp_compare_a: assert property (
        meas.tempValid &&
        $signed(meas.temp) > $signed(tempLimit_r[15:atl_pkg::TEMP_LSB_POS])
        |=> limitFlags.tempOver)
        else $error("temperature flag not set");
    // A compare on the low power bits would trip here on small results
    power_compare_a: assert property (
        !alertLatchEnable && meas.powerValid &&
        meas.power[23:atl_pkg::POWER_CMP_POS] <= powerLimit_r
        |=> !limitFlags.powerOver)
        else $error("power compare uses wrong bits");
    maker_read_a: assert property (
        regRdEn && hitMaker |=> regRdData == MAKER_ID)
        else $error("maker word wrong");
    reset_defaults_a: assert property (@(posedge core_clk)
        $past(rst) |-> shuntUnder_r == atl_pkg::RST_SHUNT_UNDER
        && busUnder_r == atl_pkg::RST_BUS_UNDER
        && powerLimit_r == atl_pkg::RST_POWER_LIMIT)
        else $error("reset limits wrong");
    step_select_a: assert property (
        shuntRangeSelect |=> shuntStepNv == atl_pkg::SHUNT_STEP_NARROW_NV)
        else $error("shunt weight wrong");
    wide_step_a: assert property (
        !shuntRangeSelect |=> shuntStepNv == atl_pkg::SHUNT_STEP_WIDE_NV)
        else $error("shunt weight not wide");

    // Write steps; reserved bits must come out cleared whatever the host sends
    sequence busOverWrS;
        regWrEn && hitBusOver;
    endsequence
    sequence busUnderWrS;
        regWrEn && hitBusUnder;
    endsequence
    sequence tempWrS;
        regWrEn && hitTemp;
    endsequence

    shunt_over_write_a: assert property (
        regWrEn && hitShuntOver |=> shuntOver_r == $past(regWrData))
        else $error("shunt over threshold not written");
    shunt_under_write_a: assert property (
        regWrEn && hitShuntUnder |=> shuntUnder_r == $past(regWrData))
        else $error("shunt under threshold not written");
    bus_over_write_a: assert property (
        busOverWrS |=> busOver_r == ($past(regWrData) & atl_pkg::MASK_BUS))
        else $error("bus over threshold not written");
    bus_under_write_a: assert property (
        busUnderWrS |=> busUnder_r == ($past(regWrData) & atl_pkg::MASK_BUS))
        else $error("bus under threshold not written");
    temp_write_a: assert property (
        tempWrS |=> tempLimit_r == ($past(regWrData) & atl_pkg::MASK_TEMP))
        else $error("temperature limit not written");
    power_write_a: assert property (
        regWrEn && hitPower |=> powerLimit_r == $past(regWrData))
        else $error("power limit not written");

    // Reads return the value held before a write in the same cycle
    over_read_a: assert property (
        regRdEn && hitShuntOver |=> regRdData == $past(shuntOver_r))
        else $error("shunt over read wrong");
    under_read_a: assert property (
        regRdEn && hitShuntUnder |=> regRdData == $past(shuntUnder_r))
        else $error("shunt under read wrong");
    temp_read_a: assert property (
        regRdEn && hitTemp |=> regRdData == $past(tempLimit_r))
        else $error("temperature limit read wrong");
    power_read_a: assert property (
        regRdEn && hitPower |=> regRdData == $past(powerLimit_r))
        else $error("power limit read wrong");

    bus_over_flag_a: assert property (
        meas.busValid && meas.bus > busOver_r |=> limitFlags.busOver)
        else $error("bus over flag not set");
    bus_under_flag_a: assert property (
        meas.busValid && meas.bus < busUnder_r |=> limitFlags.busUnder)
        else $error("bus under flag not set");
    power_flag_a: assert property (
        meas.powerValid && meas.power[23:atl_pkg::POWER_CMP_POS] > powerLimit_r
        |=> limitFlags.powerOver)
        else $error("power flag not set");
    // Without a fresh result a transparent flag must not move
    bus_hold_a: assert property (
        !alertLatchEnable && !meas.busValid |=> $stable(limitFlags.busOver))
        else $error("bus flag moved without result");
    latch_keep_a: assert property (
        alertLatchEnable && !diagRead && limitFlags.shuntOver
        |=> limitFlags.shuntOver)
        else $error("latched shunt flag dropped");
    under_clear_a: assert property (
        !alertLatchEnable && meas.shuntValid &&
        !($signed(meas.shunt) < $signed(shuntUnder_r))
        |=> !limitFlags.shuntUnder)
        else $error("transparent under flag stuck");
    temp_clear_a: assert property (
        !alertLatchEnable && meas.tempValid &&
        !($signed(meas.temp) > $signed(tempLimit_r[15:atl_pkg::TEMP_LSB_POS]))
        |=> !limitFlags.tempOver)
        else $error("transparent temperature flag stuck");
    reset_flags_a: assert property (@(posedge core_clk)
        $past(rst) |-> limitFlags == '0 && !limitAlert
        && regRdData == atl_pkg::REG_ZERO)
        else $error("reset outputs wrong");
    reset_upper_a: assert property (@(posedge core_clk)
        $past(rst) |-> shuntOver_r == atl_pkg::RST_SHUNT_OVER
        && busOver_r == atl_pkg::RST_BUS_OVER
        && tempLimit_r == atl_pkg::RST_TEMP_LIMIT)
        else $error("reset upper limits wrong");
endmodule : atl_limit_regs
`default_nettype wire

/* File: logic/atl_pkg.sv */
// Shared constants and types of the alert threshold limit register bank
package atl_pkg;
    // Register indices on the device register port
    localparam logic [7:0] ADDR_SHUNT_OVER = 8'h0C;
    localparam logic [7:0] ADDR_SHUNT_UNDER = 8'h0D;
    localparam logic [7:0] ADDR_BUS_OVER = 8'h0E;
    localparam logic [7:0] ADDR_BUS_UNDER = 8'h0F;
    localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_POWER_LIMIT = 8'h11;
    localparam logic [7:0] ADDR_MAKER_ID = 8'h3E;

    // Reset values
    localparam logic [15:0] RST_SHUNT_OVER = 16'h7FFF;
    localparam logic [15:0] RST_SHUNT_UNDER = 16'h8000;
    localparam logic [15:0] RST_BUS_OVER = 16'h7FFF;
    localparam logic [15:0] RST_BUS_UNDER = 16'h0000;
    localparam logic [15:0] RST_TEMP_LIMIT = 16'h7FF0;
    localparam logic [15:0] RST_POWER_LIMIT = 16'hFFFF;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // Writable bit masks; reserved bits read zero
    localparam logic [15:0] MASK_FULL = 16'hFFFF;
    localparam logic [15:0] MASK_BUS = 16'h7FFF;
    localparam logic [15:0] MASK_TEMP = 16'hFFF0;
    localparam int TEMP_LSB_POS = 4;
    localparam int POWER_CMP_POS = 8;

    // Shunt threshold weight in nanovolts per count
    localparam logic [15:0] SHUNT_STEP_WIDE_NV = 16'h1388;
    localparam logic [15:0] SHUNT_STEP_NARROW_NV = 16'h04E2;

    localparam int NUM_FLAGS = 6;

    // Flags in diagnostic bit order
    typedef struct packed {
        logic tempOver;
        logic shuntOver;
        logic shuntUnder;
        logic busOver;
        logic busUnder;
        logic powerOver;
    } atl_flags_t;

    // One new measurement set from the conversion engine
    typedef struct packed {
        logic        shuntValid;
        logic [15:0] shunt;
        logic        busValid;
        logic [15:0] bus;
        logic        tempValid;
        logic [11:0] temp;
        logic        powerValid;
        logic [23:0] power;
    } atl_meas_t;
endpackage : atl_pkg

/* File: tb/alert_threshold_limit_registers_bench.sv */
// Self-checking bench for the alert threshold limit register bank
`timescale 1ns/100ps
`default_nettype none
module alert_threshold_limit_registers_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr;
    logic regWrEn, regRdEn, shuntRangeSelect = 1'b0, alertLatchEnable = 1'b0, diagRead = 1'b0;
    logic [15:0] regWrData, regRdData, shuntStepNv, rdv;
    atl_pkg::atl_meas_t meas = '0;
    atl_pkg::atl_flags_t limitFlags;
    logic limitAlert;
    int failures = 0;
    int total_checks = 0;
    logic [7:0] addrs [8] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h3E, 8'h20};
    logic [15:0] rstv [8] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h7FF0, 16'hFFFF,
                              16'h4142, 16'h0000};
    logic [15:0] wrv [8] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFF0, 16'hFFFF,
                             16'h4142, 16'h0000};
    initial forever #5 core_clk = ~core_clk;
    atl_host_model i_atl_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
    // Identification value is arbitrary
    atl_limit_regs #(.MAKER_ID(16'h4142)) i_atl_limit_regs (.core_clk(core_clk), .rst(rst),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .meas(meas), .shuntRangeSelect(shuntRangeSelect),
        .alertLatchEnable(alertLatchEnable), .diagRead(diagRead), .shuntStepNv(shuntStepNv),
        .limitFlags(limitFlags), .limitAlert(limitAlert));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // One measurement pulse, then flags and alert one cycle on
    task automatic trig(input atl_pkg::atl_meas_t m, input logic [5:0] exp);
        @(posedge core_clk);
        meas <= m;
        @(posedge core_clk);
        meas <= '0;
        #1;
        cmp({10'h000, limitFlags}, {10'h000, exp});
        cmp({15'h0000, limitAlert}, {15'h0000, |exp});
    endtask : trig
    // One diagnostic read pulse, then flags and alert checked one cycle on
    task automatic diag(input logic [6:0] exp);
        @(posedge core_clk);
        diagRead <= 1'b1;
        @(posedge core_clk);
        diagRead <= 1'b0;
        #1;
        cmp({9'h000, limitFlags, limitAlert}, {9'h000, exp});
    endtask : diag
    function automatic atl_pkg::atl_meas_t sh(logic [15:0] v);
        return '{shuntValid: 1'b1, shunt: v, default: '0};
    endfunction : sh
    function automatic atl_pkg::atl_meas_t bu(logic [15:0] v);
        return '{busValid: 1'b1, bus: v, default: '0};
    endfunction : bu
    function automatic atl_pkg::atl_meas_t tp(logic [11:0] v);
        return '{tempValid: 1'b1, temp: v, default: '0};
    endfunction : tp
    function automatic atl_pkg::atl_meas_t pw(logic [23:0] v);
        return '{powerValid: 1'b1, power: v, default: '0};
    endfunction : pw
    task automatic results;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        results();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, then masked write-back of all ones
        for (int i = 0; i < 8; i++) begin
            i_atl_host_model.rd(addrs[i], rdv);
            cmp(rdv, rstv[i]);
            i_atl_host_model.wr(addrs[i], 16'hFFFF);
            i_atl_host_model.rd(addrs[i], rdv);
            cmp(rdv, wrv[i]);
        end
        i_atl_host_model.wrShuntPair(16'hFFFE, 16'hFFFF);
        trig(sh(16'h0000), 6'b010000);
        trig(sh(16'hFFFD), 6'b001000);
        trig(sh(16'hFFFF), 6'b000000);
        i_atl_host_model.wr(8'h0E, 16'h0010);
        i_atl_host_model.wr(8'h0F, 16'h0005);
        trig(bu(16'h0011), 6'b000100);
        trig(bu(16'h0004), 6'b000010);
        trig(bu(16'h0010), 6'b000000);
        i_atl_host_model.wr(8'h10, 16'h0100);
        trig(tp(12'h011), 6'b100000);
        trig(tp(12'hFFF), 6'b000000);
        i_atl_host_model.wr(8'h11, 16'h0001);
        trig(pw(24'h00_01FF), 6'b000000);
        trig(pw(24'h00_0200), 6'b000001);
        // Transparent mode: a diagnostic read leaves the flag alone
        diag(7'h03);
        trig(pw(24'h00_0100), 6'b000000);
        @(posedge core_clk);
        alertLatchEnable <= 1'b1;
        trig(sh(16'h0000), 6'b010000);
        trig(sh(16'hFFFF), 6'b010000);
        diag(7'h00);
        // Trip and diagnostic read in one cycle: the trip wins
        @(posedge core_clk);
        diagRead <= 1'b1;
        meas <= sh(16'h0000);
        @(posedge core_clk);
        diagRead <= 1'b0;
        meas <= '0;
        #1;
        cmp({9'h000, limitFlags, limitAlert}, 16'h0021);
        @(posedge core_clk);
        shuntRangeSelect <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        cmp(shuntStepNv, 16'h04E2);
        @(posedge core_clk);
        shuntRangeSelect <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        cmp(shuntStepNv, 16'h1388);
        results();
    end
endmodule : alert_threshold_limit_registers_bench
`default_nettype wire

/* File: tb/atl_host_model.sv */
// Host side model issuing transfers on the device register port
`timescale 1ns/100ps
`default_nettype none
module atl_host_model (
    input  wire logic        core_clk,
    output logic      [7:0]  regAddr,
    output logic             regWrEn,
    output logic      [15:0] regWrData,
    output logic             regRdEn,
    input  wire logic [15:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 16'h0000;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrEn <= 1'b1;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        // Released data line must not keep showing the last word
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd
    task automatic wrShuntPair(input logic signed [15:0] a, input logic signed [15:0] b);
        wr(atl_pkg::ADDR_SHUNT_OVER, (a > b) ? a : b);
        wr(atl_pkg::ADDR_SHUNT_UNDER, (a > b) ? b : a);
    endtask : wrShuntPair
endmodule : atl_host_model
`default_nettype wire
